// file: verilog/gsff_pkg.sv
// Constants for the gated set/clear flip-flop
package gsff_pkg;
  localparam logic STATE_ONE = 1'b1;
  localparam logic STATE_ZERO = 1'b0;
  localparam logic RESET_STATE = 1'b0;
  // Index of each gated side in the per-side vectors
  localparam int SIDE_SET = 0;
  localparam int SIDE_CLR = 1;
  localparam int N_SIDES = 2;
  // Standard trigger pulse width in ns and in clock cycles at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int PULSE_NS = 100;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// file: verilog/gsff_top.sv
// Gated set/clear/complement storage flip-flop with direct and collector inputs
`timescale 1ns/100ps
module gsff_top
  import gsff_pkg::*;
(
  input wire logic clk_i,         // System clock, 10 MHz
  input wire logic rst_i,         // Synchronous reset, active high
  input wire logic set_pulse_i,   // Gated set pulse input
  input wire logic set_en_i,      // Level enable for gated set
  input wire logic clr_pulse_i,   // Gated clear pulse input
  input wire logic clr_en_i,      // Level enable for gated clear
  input wire logic dir_set_i,     // Direct set level
  input wire logic dir_clr_i,     // Direct clear level
  input wire logic coll_clr_i,    // Collector clear on true terminal (gates ORed)
  input wire logic coll_set_i,    // Collector force on complement terminal
  output logic one_o,             // True output, high in one state
  output logic zero_o             // Complementary output
);
  import gsff_pkg::*;

  logic state_ff;
  logic one_ff;
  logic zero_ff;
  logic nxt_state;
  logic nxt_one;
  logic nxt_zero;
  logic gated_next;
  logic force_clr;
  logic force_set;
  logic [N_SIDES-1:0] pulse_in;
  logic [N_SIDES-1:0] en_in;
  logic [N_SIDES-1:0] pulse_ff;
  logic [N_SIDES-1:0] en_ff;
  logic [N_SIDES-1:0] nxt_pulse;
  logic [N_SIDES-1:0] nxt_en;
  logic [N_SIDES-1:0] side_edge;
  logic [N_SIDES-1:0] side_gated;
  logic [N_SIDES-1:0] side_fire;

  // State that a gated side drives the element to
  function automatic logic side_target(input int side);
    logic target;
    target = STATE_ZERO;
    if (side == SIDE_SET)
    begin
      target = STATE_ONE;
    end
    return target;
  endfunction

  // A side is armed only while the element still differs from its target
  function automatic logic side_armed(input logic state, input logic target);
    logic armed;
    armed = 1'b0;
    if (state != target)
    begin
      armed = 1'b1;
    end
    return armed;
  endfunction

  // Forcing levels beat the gated path; clear wins when both are forced
  function automatic logic force_pick(input logic clr, input logic set, input logic keep);
    logic pick;
    pick = keep;
    if (clr)
    begin
      pick = STATE_ZERO;
    end
    else if (set)
    begin
      pick = STATE_ONE;
    end
    return pick;
  endfunction

  // Per-side views of the gated inputs
  assign pulse_in[SIDE_SET] = set_pulse_i;
  assign pulse_in[SIDE_CLR] = clr_pulse_i;
  assign en_in[SIDE_SET] = set_en_i;
  assign en_in[SIDE_CLR] = clr_en_i;

  genvar g;
  generate
    for (g = 0; g < N_SIDES; g++)
    begin : g_side
      assign side_edge[g] = pulse_in[g] & ~pulse_ff[g];

      // enable taken one cycle before the edge
      assign side_gated[g] = side_edge[g] & en_ff[g];

      assign side_fire[g] = side_gated[g] & side_armed(state_ff, side_target(g));

      // Low history after reset, so an idle-low pin gives no false edge
      assign nxt_pulse[g] = rst_i ? 1'b0 : pulse_in[g];

      // Enable delay stands in for the level memory of the input gate
      assign nxt_en[g] = rst_i ? 1'b0 : en_in[g];

      always_ff @(posedge clk_i)
      begin
        pulse_ff[g] <= nxt_pulse[g];
      end

      always_ff @(posedge clk_i)
      begin
        en_ff[g] <= nxt_en[g];
      end
    end
  endgenerate

  // joined pulses toggle; the two armed sides never fire together
  assign gated_next = side_fire[SIDE_SET] ? STATE_ONE :
    (side_fire[SIDE_CLR] ? STATE_ZERO : state_ff);

  // direct levels bypass the pulse gating
  assign force_clr = dir_clr_i | coll_clr_i;
  assign force_set = dir_set_i | coll_set_i;

  assign nxt_state = force_pick(force_clr, force_set, gated_next);

  // outputs load with the state, never one cycle behind it
  assign nxt_one = rst_i ? RESET_STATE : nxt_state;
  assign nxt_zero = rst_i ? ~RESET_STATE : ~nxt_state;

  // state register holds unless a command arrives
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= RESET_STATE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_i)
  begin
    one_ff <= nxt_one;
  end

  always_ff @(posedge clk_i)
  begin
    zero_ff <= nxt_zero;
  end

  assign one_o = one_ff;
  assign zero_o = zero_ff;
endmodule

// file: sim/gsff_pulse_src.sv
// Trigger pulse source model
`timescale 1ns/100ps
module gsff_pulse_src (
  input wire logic clk_i, // Clock
  input wire logic fire_i, // Request one pulse
  output logic pulse_o // Trigger pulse
);
  initial pulse_o = 1'b0;
  always @(negedge clk_i) pulse_o <= fire_i;
endmodule

// file: sim/gsff_assertions.sv
// Checker for the flip-flop ports
`timescale 1ns/100ps
module gsff_chk (input wire logic clk_i, rst_i, set_pulse_i, set_en_i, clr_pulse_i,
  clr_en_i, dir_set_i, dir_clr_i, coll_clr_i, coll_set_i, one_o, zero_o);
  wire nf = !(dir_set_i | dir_clr_i | coll_set_i | coll_clr_i);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  compl_out_a: assert property (zero_o == !one_o) else $error("bad complement");
  force_clr_a: assert property (dir_clr_i | coll_clr_i |=> !one_o) else $error("no clear");
  force_set_a: assert property ((dir_set_i | coll_set_i) && !dir_clr_i && !coll_clr_i
    |=> one_o) else $error("no set");
  gated_set_a: assert property (nf && !set_pulse_i && set_en_i && !one_o
    ##1 nf && set_pulse_i |=> one_o) else $error("gated set lost");
  gated_clr_a: assert property (nf && !clr_pulse_i && clr_en_i && one_o
    ##1 nf && clr_pulse_i |=> !one_o) else $error("gated clear lost");
  hold_a: assert property (nf && !set_pulse_i && !clr_pulse_i |=> $stable(one_o))
    else $error("state drifted");
  no_enable_a: assert property (nf && !set_en_i && !clr_en_i ##1 nf |=> $stable(one_o))
    else $error("ungated change");
  toggle_a: assert property (nf && !set_pulse_i && !clr_pulse_i && set_en_i && clr_en_i
    ##1 nf && set_pulse_i && clr_pulse_i |=> one_o != $past(one_o)) else $error("no toggle");
  cover property (set_pulse_i && clr_pulse_i);
  cover property (dir_set_i);
  cover property (coll_clr_i);
endmodule
bind gsff_top gsff_chk i_gsff_chk (.clk_i, .rst_i, .set_pulse_i, .set_en_i, .clr_pulse_i,
  .clr_en_i, .dir_set_i, .dir_clr_i, .coll_clr_i, .coll_set_i, .one_o, .zero_o);

// file: sim/gsff_top_tb.sv
// Self-checking bench for the flip-flop
`timescale 1ns/100ps
module gsff_top_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, set_en_i = 1'b0, clr_en_i = 1'b0, one_o, zero_o;
  logic [3:0] frc = 4'h0;
  logic [2:0] fire = 3'h0, pl;
  int miscompares = 0, n_compared = 0;
  gsff_pulse_src i_gsff_pulse_src [2:0] (.clk_i(clk_i), .fire_i(fire), .pulse_o(pl));
  gsff_top i_gsff_top (.clk_i(clk_i), .rst_i(rst_i), .set_pulse_i(pl[2] | pl[0]),
    .set_en_i(set_en_i), .clr_pulse_i(pl[1] | pl[0]), .clr_en_i(clr_en_i),
    .dir_set_i(frc[3]), .dir_clr_i(frc[2]), .coll_set_i(frc[1]), .coll_clr_i(frc[0]),
    .one_o(one_o), .zero_o(zero_o));
  initial forever #50 clk_i = ~clk_i;
  task check(input logic [1:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  // Enables drop as the pulse rises
  task cmd(input logic [2:0] f, input logic [1:0] en, input logic exp);
    fire <= f;
    {set_en_i, clr_en_i} <= en;
    @(negedge clk_i);
    fire <= 3'h0;
    {set_en_i, clr_en_i} <= 2'h0;
    repeat (2) @(negedge clk_i);
    check({one_o, zero_o}, {exp, ~exp});
  endtask
  task t_direct;
    for (int i = 0; i < 4; i++)
    begin
      frc <= 4'h8 >> i; // one forcing level at a time
      @(negedge clk_i);
      frc <= 4'h0;
      @(negedge clk_i);
      check({one_o, zero_o}, i[0] ? 2'h1 : 2'h2);
    end
    $display("direct test done");
  endtask
  task wrap_up;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(negedge clk_i);
    rst_i <= 1'b0;
    cmd(3'h4, 2'h0, 1'b0);
    cmd(3'h4, 2'h2, 1'b1);
    cmd(3'h2, 2'h0, 1'b1);
    cmd(3'h2, 2'h1, 1'b0);
    cmd(3'h1, 2'h3, 1'b1);
    cmd(3'h1, 2'h3, 1'b0);
    $display("gated test done");
    t_direct;
    wrap_up;
  end
endmodule
